// *** verif/hwk_spk_model.sv ***
module hwk_spk_model (
    input  wire logic clk_in,
    input  wire logic sound_in,
    input  wire logic pin_neg_in,
    input  wire logic drive_in,
    output logic      compare_wake_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic float_r = 1'b0;
    always @(posedge clk_in) begin
        float_r <= ~float_r;
    end
    // high while the neg pin sits above the reference; released pin floats
    assign compare_wake_out = drive_in ? (pin_neg_in | sound_in) : float_r;
endmodule

// *** verif/hwk_wake_sva.sv ***
module hwk_wake_sva
    import hwk_pkg::*;
(
    input wire logic        clk_in,
    input wire logic        rst_in,
    input wire logic        psel_in,
    input wire logic        penable_in,
    input wire logic [31:0] paddr_in,
    input wire logic        pslverr_out,
    input wire logic        audio_pos_in,
    input wire logic        audio_neg_in,
    input wire logic        compare_wake_in,
    input wire logic        power_on_reset_in,
    input wire logic        low_voltage_reset_in,
    input wire logic        external_reset_n_in,
    input wire logic        watchdog_reset_in,
    input wire logic        audio_out_pos_out,
    input wire logic        audio_out_neg_out,
    input wire logic        audio_oe_out,
    input wire logic        halted_out,
    input wire logic        wake_out,
    input wire logic [11:0] wake_vector_out,
    input wire logic        sys_reset_out,
    input wire logic        irq_out
);
    logic [7:0] ix;
    logic       mapped;
    assign ix = paddr_in[9:2];
    assign mapped = paddr_in[31:10] == 0 && paddr_in[1:0] == 0 &&
        ix inside {SPK_WAKE_IDX, TMR_CTRL_IDX, TMR_CLEAR_IDX,
                   IRQ_STAT_IDX, IRQ_MASK_IDX, HALT_CTRL_IDX};
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    vector_fixed_a: assert property (wake_vector_out == WAKE_VECTOR)
        else $error("wake vector wrong");
    pins_ground_a: assert property (halted_out && audio_oe_out
        |-> !audio_out_pos_out && !audio_out_neg_out) else $error("pins up");
    run_pass_a: assert property (!halted_out && audio_oe_out
        |-> audio_out_pos_out == audio_pos_in
            && audio_out_neg_out == audio_neg_in) else $error("no pass");
    spk_wake_a: assert property (halted_out && audio_oe_out
        && compare_wake_in |=> wake_out) else $error("no speaker wake");
    wake_exit_a: assert property (wake_out
        |-> !halted_out && $past(halted_out)) else $error("bad wake");
    wake_pulse_a: assert property (wake_out |=> !wake_out)
        else $error("wake pulse long");
    reset_comb_a: assert property (sys_reset_out ==
        $past(power_on_reset_in || low_voltage_reset_in
              || !external_reset_n_in || watchdog_reset_in))
        else $error("reset sources not combined");
    reset_run_a: assert property (sys_reset_out |-> !halted_out)
        else $error("halt kept in reset");
    bad_addr_a: assert property (pslverr_out ==
        (psel_in && penable_in && !mapped)) else $error("slave error wrong");
    cover property (wake_out && !compare_wake_in);
    cover property (wake_out && compare_wake_in);
    cover property ($rose(irq_out));
endmodule

bind hwk_wake hwk_wake_sva chk (.*);

// *** verif/tb_top.sv ***
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import hwk_pkg::*;
    logic clk_in = 0, rst_in = 1, ce_in = 1, psel_in = 0, penable_in = 0;
    logic pwrite_in = 0, halt_req_in = 0, audio_pos_in = 0, audio_neg_in = 0;
    logic power_on_reset_in = 0, low_voltage_reset_in = 0, sound = 0;
    logic watchdog_reset_in = 0, external_reset_n_in = 1, err;
    logic [31:0] paddr_in = 0, pwdata_in = 0, prdata_out, rd;
    logic pready_out, pslverr_out, compare_wake_in, audio_oe_out, irq_out;
    logic audio_out_pos_out, audio_out_neg_out, halted_out, wake_out;
    logic sys_reset_out;
    logic [11:0] wake_vector_out;
    int errors = 0, comparisons = 0, n;
    int ticks[4] = '{100, 1600, 6400, 12800};
    initial begin
        forever #4 clk_in = ~clk_in;
    end
    hwk_wake #(.LRO_DIVIDE(2)) dut (.*);
    hwk_spk_model spk (.clk_in(clk_in), .sound_in(sound),
        .pin_neg_in(audio_out_neg_out), .drive_in(audio_oe_out),
        .compare_wake_out(compare_wake_in));
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %0t got %h want %h", $time, seen, exp);
        end
    endtask
    task final_report;
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task xfer(input logic w, input logic [7:0] ix, input logic [3:0] d);
        @(posedge clk_in);
        psel_in <= 1;
        pwrite_in <= w;
        paddr_in <= {22'h0, ix, 2'h0};
        pwdata_in <= {28'h0, d};
        @(posedge clk_in);
        penable_in <= 1;
        @(posedge clk_in);
        while (pready_out !== 1'b1) @(posedge clk_in);
        rd = prdata_out;
        err = pslverr_out;
        psel_in <= 0;
        penable_in <= 0;
    endtask
    task rdchk(input logic [7:0] ix, input logic [31:0] exp);
        xfer(0, ix, 4'h0);
        chk(rd, exp);
    endtask
    task halt;
        @(posedge clk_in);
        halt_req_in <= 1;
        @(posedge clk_in);
        halt_req_in <= 0;
        #1;
    endtask
    task srst(input int i);
        @(posedge clk_in);
        case (i)
            0: power_on_reset_in <= 1;
            1: low_voltage_reset_in <= 1;
            2: external_reset_n_in <= 0;
            default: watchdog_reset_in <= 1;
        endcase
        @(posedge clk_in);
        {power_on_reset_in, low_voltage_reset_in, watchdog_reset_in} <= 0;
        external_reset_n_in <= 1;
        #1;
        chk(sys_reset_out, 1);
        chk(halted_out, 0);
    endtask
    initial begin
        repeat (16) @(posedge clk_in);
        rst_in <= 0;
        rdchk(SPK_WAKE_IDX, SPK_WAKE_RST);
        rdchk(TMR_CTRL_IDX, TMR_CTRL_RST);
        xfer(1, 8'h30, 4'hF);
        chk(err, 1);
        rdchk(8'h30, 0);
        xfer(1, IRQ_MASK_IDX, 4'h1);
        for (int s = 0; s < 4; s++) begin
            xfer(1, TMR_CTRL_IDX, 4'hC | 4'(s));
            xfer(1, TMR_CLEAR_IDX, TMR_CLEAR_KEY);
            repeat (2 * ticks[s] - 12) @(posedge clk_in);
            rdchk(TMR_CTRL_IDX, 4'h4 | 4'(s));
            repeat (20) @(posedge clk_in);
            rdchk(TMR_CTRL_IDX, 4'hC | 4'(s));
            chk(irq_out, 1);
            xfer(1, IRQ_MASK_IDX, 4'h0);
            #1 chk(irq_out, 0);
            xfer(1, IRQ_MASK_IDX, 4'h1);
            xfer(1, IRQ_STAT_IDX, 4'h1);
            #1 chk(irq_out, 0);
        end
        xfer(1, TMR_CTRL_IDX, 4'hC);
        xfer(1, TMR_CLEAR_IDX, TMR_CLEAR_KEY);
        halt();
        chk(halted_out, 1);
        for (n = 0; wake_out !== 1'b1 && n < 400; n++) @(posedge clk_in);
        chk(n inside {[180:205]}, 1);
        chk(wake_vector_out, WAKE_VECTOR);
        rdchk(HALT_CTRL_IDX, 0);
        for (int i = 0; i < 4; i++) begin
            halt();
            chk(audio_oe_out, 0);
            srst(i);
            rdchk(HALT_CTRL_IDX, 0);
        end
        xfer(1, SPK_WAKE_IDX, 4'h7);
        rdchk(SPK_WAKE_IDX, 4'h7);
        xfer(1, IRQ_MASK_IDX, 4'h2);
        sound <= 1;
        audio_pos_in <= 1;
        audio_neg_in <= 1;
        repeat (5) @(posedge clk_in);
        #1 chk(audio_out_pos_out, 1);
        chk(audio_out_neg_out, 1);
        rdchk(HALT_CTRL_IDX, 0);
        sound <= 0;
        audio_pos_in <= 0;
        audio_neg_in <= 0;
        // audio silent before halting
        repeat (20) @(posedge clk_in);
        halt();
        chk({audio_out_pos_out, audio_out_neg_out, audio_oe_out}, 1);
        rdchk(HALT_CTRL_IDX, 1);
        sound <= 1;
        for (n = 0; wake_out !== 1'b1 && n < 20; n++) @(posedge clk_in);
        chk(wake_out, 1);
        chk(irq_out, 1);
        sound <= 0;
        rdchk(SPK_WAKE_IDX, 4'hF);
        xfer(1, SPK_WAKE_IDX, 4'h9);
        rdchk(SPK_WAKE_IDX, 4'h1);
        // clock enable low freezes the timer while halted
        xfer(1, TMR_CTRL_IDX, 4'hC);
        xfer(1, TMR_CLEAR_IDX, TMR_CLEAR_KEY);
        halt();
        @(posedge clk_in);
        ce_in <= 0;
        repeat (300) @(posedge clk_in);
        chk({halted_out, wake_out}, 2);
        ce_in <= 1;
        for (n = 0; wake_out !== 1'b1 && n < 400; n++) @(posedge clk_in);
        chk(n inside {[180:205]}, 1);
        srst(2);
        final_report();
    end
    initial begin
        #480000;
        errors++;
        final_report();
    end
endmodule

// *** verilog/hwk_period_timer.sv ***
module hwk_period_timer
    import hwk_pkg::*;
#(
    parameter int DIV = LRO_DIV
) (
    input  wire logic clk_in,
    input  wire logic rst_in,
    input  wire logic ce_in,
    hwk_tick_if.tmr   tb
);
    import hwk_pkg::*;

    initial begin
        if (DIV < 1) $error("DIV must be at least 1");
    end

    typedef struct packed {
        logic [15:0]      div;
        logic [CNT_W-1:0] cnt;
        logic             tick;
        logic             ovf;
    } hwk_tmr_state_t;

    hwk_tmr_state_t s_r;
    hwk_tmr_state_t s_nxt;
    logic [CNT_W-1:0] limit;

    always_comb begin
        case (tb.sel)
            2'b00:   limit = CNT_W'(TICKS_1MS - 1);
            2'b01:   limit = CNT_W'(TICKS_16MS - 1);
            2'b10:   limit = CNT_W'(TICKS_64MS - 1);
            2'b11:   limit = CNT_W'(TICKS_128MS - 1);
            default: limit = CNT_W'(TICKS_1MS - 1);
        endcase
    end

    always_comb begin
        s_nxt      = s_r;
        s_nxt.tick = 1'b0;
        s_nxt.ovf  = 1'b0;
        // low-rate oscillator tick
        if (s_r.div == 16'(DIV - 1)) begin
            s_nxt.div  = '0;
            s_nxt.tick = 1'b1;
        end else begin
            s_nxt.div = s_r.div + 16'h0001;
        end
        if (tb.clear) begin
            s_nxt.cnt = '0;
            s_nxt.div = '0;
        end else if (tb.enable && s_r.tick) begin
            if (s_r.cnt >= limit) begin
                s_nxt.cnt = '0;
                s_nxt.ovf = 1'b1;
            end else begin
                s_nxt.cnt = s_r.cnt + CNT_W'(1);
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            s_r <= '0;
        end else if (ce_in) begin
            s_r <= s_nxt;
        end
    end

    assign tb.tick = s_r.tick;
    assign tb.ovf  = s_r.ovf;
endmodule

// *** verilog/hwk_pkg.sv ***
package hwk_pkg;
    // register offsets (printed offsets are not multiples of four: index)
    localparam logic [7:0]  SPK_WAKE_IDX    = 8'h12;
    localparam logic [7:0]  TMR_CTRL_IDX    = 8'h16;
    localparam logic [7:0]  TMR_CLEAR_IDX   = 8'h1D;
    localparam logic [7:0]  IRQ_STAT_IDX    = 8'h20;
    localparam logic [7:0]  IRQ_MASK_IDX    = 8'h21;
    localparam logic [7:0]  HALT_CTRL_IDX   = 8'h22;
    // speaker wake register fields
    localparam int          SPK_EN_BIT      = 0;
    localparam int          CLAP_LO_BIT     = 1;
    localparam int          CLAP_HI_BIT     = 2;
    localparam int          SPK_FLAG_BIT    = 3;
    // periodic timer register fields
    localparam int          SEL_LO_BIT      = 0;
    localparam int          SEL_HI_BIT      = 1;
    localparam int          TMR_EN_BIT      = 2;
    localparam int          TMR_FLAG_BIT    = 3;
    // interrupt status / mask fields
    localparam int          IRQ_TMR_BIT     = 0;
    localparam int          IRQ_SPK_BIT     = 1;
    localparam int          IRQ_WIDTH       = 2;
    // reset values, clear key and wake vector
    localparam logic [3:0]  SPK_WAKE_RST    = 4'h0;
    localparam logic [3:0]  TMR_CTRL_RST    = 4'h0;
    localparam logic [3:0]  TMR_CLEAR_KEY   = 4'hA;
    localparam logic [11:0] WAKE_VECTOR     = 12'h004;
    // timing
    localparam int          CLK_HZ          = 125_000_000;
    localparam int          LRO_HZ          = 100_000;
    localparam int          LRO_DIV         = CLK_HZ / LRO_HZ;
    localparam int          PERIOD_1MS      = 1;
    localparam int          PERIOD_16MS     = 16;
    localparam int          PERIOD_64MS     = 64;
    localparam int          PERIOD_128MS    = 128;
    localparam int          TICKS_PER_MS    = LRO_HZ / 1000;
    localparam int          TICKS_1MS       = PERIOD_1MS * TICKS_PER_MS;
    localparam int          TICKS_16MS      = PERIOD_16MS * TICKS_PER_MS;
    localparam int          TICKS_64MS      = PERIOD_64MS * TICKS_PER_MS;
    localparam int          TICKS_128MS     = PERIOD_128MS * TICKS_PER_MS;
    localparam int          CNT_W           = 14;

    typedef enum logic [1:0] {
        HWK_RUN  = 2'b00,
        HWK_HALT = 2'b01,
        HWK_WAKE = 2'b10
    } hwk_mode_t;
endpackage

// *** verilog/hwk_tick_if.sv ***
interface hwk_tick_if;
    logic       tick;
    logic       ovf;
    logic       clear;
    logic       enable;
    logic [1:0] sel;
    modport ctl (output clear, output enable, output sel,
                 input tick, input ovf);
    modport tmr (input clear, input enable, input sel,
                 output tick, output ovf);
endinterface

// *** verilog/hwk_wake.sv ***
// Functional notes
// - speaker wake arms only once halted; in run mode audio passes through.
// - while armed both audio output pins are driven to ground.
// - comparator output high (negative pin above reference) wakes from halt.
// - an enabled periodic timer counts in both run and halt modes.
// - timer overflow in halt wakes the processor to vector 004h.
// - each overflow sets a sticky flag that only software or a reset clears.
// - period select 00/01/10/11 gives 1/16/64/128 ms.
// - the timer counts ticks of a 100 kHz low-rate oscillator.
// - writing Ah to the clear register zeroes the timer counter.
// - power-on, low-voltage, external pin and watchdog resets are combined.
// - a reset during halt returns clocking to normal mode.
//
// Local design decision: the APB interface to the registers.
module hwk_wake
    import hwk_pkg::*;
#(
    parameter int LRO_DIVIDE = LRO_DIV
) (
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    input  wire logic        ce_in,
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [31:0] paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic      [31:0] prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    input  wire logic        halt_req_in,
    input  wire logic        audio_pos_in,
    input  wire logic        audio_neg_in,
    input  wire logic        compare_wake_in,
    input  wire logic        power_on_reset_in,
    input  wire logic        low_voltage_reset_in,
    input  wire logic        external_reset_n_in,
    input  wire logic        watchdog_reset_in,
    output logic             audio_out_pos_out,
    output logic             audio_out_neg_out,
    output logic             audio_oe_out,
    output logic             halted_out,
    output logic             wake_out,
    output logic [11:0]      wake_vector_out,
    output logic             sys_reset_out,
    output logic             irq_out
);
    import hwk_pkg::*;

    initial begin
        if (LRO_DIVIDE < 1 || LRO_DIVIDE > 65535)
            $error("LRO_DIVIDE out of range");
    end

    typedef struct packed {
        hwk_mode_t              mode;
        logic [3:0]             spk;
        logic [3:0]             tmr;
        logic [3:0]             clr;
        logic [IRQ_WIDTH-1:0]   stat;
        logic [IRQ_WIDTH-1:0]   mask;
        logic                   armed;
        logic                   wake;
        logic                   sysrst;
        logic [31:0]            rdata;
    } hwk_state_t;

    hwk_state_t s_r;
    hwk_state_t s_nxt;

    hwk_tick_if tbus();

    logic       wr_acc;
    logic       rd_acc;
    logic [7:0] idx;
    logic       mapped;
    logic [3:0] wd;
    logic       spk_ev;
    logic       tmr_ev;
    logic       any_reset;

    // apb decode, zero wait states
    assign idx    = paddr_in[9:2];
    assign wd     = pwdata_in[3:0];
    assign wr_acc = psel_in && penable_in && pwrite_in;
    assign rd_acc = psel_in && !penable_in && !pwrite_in;
    assign mapped = (paddr_in[1:0] == 2'b00) && (paddr_in[31:10] == '0) &&
                    (idx == SPK_WAKE_IDX || idx == TMR_CTRL_IDX ||
                     idx == TMR_CLEAR_IDX || idx == IRQ_STAT_IDX ||
                     idx == IRQ_MASK_IDX || idx == HALT_CTRL_IDX);

    // combined reset sources
    assign any_reset = power_on_reset_in || low_voltage_reset_in ||
                       !external_reset_n_in || watchdog_reset_in;

    assign tmr_ev = tbus.ovf;
    assign spk_ev = s_r.armed && compare_wake_in;

    // timer control
    assign tbus.enable = s_r.tmr[TMR_EN_BIT];
    assign tbus.sel    = {s_r.tmr[SEL_HI_BIT], s_r.tmr[SEL_LO_BIT]};
    assign tbus.clear  = wr_acc && mapped && idx == TMR_CLEAR_IDX &&
                         wd == TMR_CLEAR_KEY;

    hwk_period_timer #(
        .DIV (LRO_DIVIDE)
    ) u_timer (
        .clk_in (clk_in),
        .rst_in (rst_in),
        .ce_in  (ce_in),
        .tb     (tbus.tmr)
    );

    always_comb begin
        s_nxt        = s_r;
        s_nxt.wake   = 1'b0;
        s_nxt.sysrst = any_reset;

        // software writes
        if (wr_acc && mapped) begin
            case (idx)
                SPK_WAKE_IDX: begin
                    s_nxt.spk[2:0] = wd[2:0];
                    if (wd[SPK_FLAG_BIT])
                        s_nxt.spk[SPK_FLAG_BIT] = 1'b0;
                end
                TMR_CTRL_IDX: begin
                    s_nxt.tmr[2:0] = wd[2:0];
                    if (wd[TMR_FLAG_BIT])
                        s_nxt.tmr[TMR_FLAG_BIT] = 1'b0;
                end
                TMR_CLEAR_IDX: s_nxt.clr = wd;
                IRQ_STAT_IDX:  s_nxt.stat = s_r.stat & ~wd[IRQ_WIDTH-1:0];
                IRQ_MASK_IDX:  s_nxt.mask = wd[IRQ_WIDTH-1:0];
                default: ;
            endcase
        end

        // mode sequencing
        case (s_r.mode)
            HWK_RUN: begin
                if (halt_req_in) begin
                    s_nxt.mode  = HWK_HALT;
                    s_nxt.armed = s_r.spk[SPK_EN_BIT];
                end
            end
            HWK_HALT: begin
                if (tmr_ev || spk_ev) begin
                    s_nxt.mode  = HWK_WAKE;
                    s_nxt.armed = 1'b0;
                    s_nxt.wake  = 1'b1;
                end
            end
            HWK_WAKE: s_nxt.mode = HWK_RUN;
            default:  s_nxt.mode = HWK_RUN;
        endcase

        // hardware set wins over software clear
        if (tmr_ev) begin
            s_nxt.tmr[TMR_FLAG_BIT] = 1'b1;
            s_nxt.stat[IRQ_TMR_BIT] = 1'b1;
        end
        if (spk_ev && s_r.mode == HWK_HALT) begin
            s_nxt.spk[SPK_FLAG_BIT] = 1'b1;
            s_nxt.stat[IRQ_SPK_BIT] = 1'b1;
        end

        // read data sampled in setup cycle
        s_nxt.rdata = '0;
        if (rd_acc && mapped) begin
            case (idx)
                SPK_WAKE_IDX:  s_nxt.rdata[3:0] = s_r.spk;
                TMR_CTRL_IDX:  s_nxt.rdata[3:0] = s_r.tmr;
                TMR_CLEAR_IDX: s_nxt.rdata[3:0] = s_r.clr;
                IRQ_STAT_IDX:  s_nxt.rdata[IRQ_WIDTH-1:0] = s_r.stat;
                IRQ_MASK_IDX:  s_nxt.rdata[IRQ_WIDTH-1:0] = s_r.mask;
                HALT_CTRL_IDX: s_nxt.rdata[1:0] = s_r.mode;
                default:       s_nxt.rdata = '0;
            endcase
        end

        // reset while halted returns to run mode
        if (any_reset) begin
            s_nxt.mode  = HWK_RUN;
            s_nxt.armed = 1'b0;
            s_nxt.spk   = SPK_WAKE_RST;
            s_nxt.tmr   = TMR_CTRL_RST;
            s_nxt.stat  = '0;
            s_nxt.mask  = '0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            s_r       <= '0;
            s_r.mode  <= HWK_RUN;
            s_r.spk   <= SPK_WAKE_RST;
            s_r.tmr   <= TMR_CTRL_RST;
        end else if (ce_in) begin
            s_r <= s_nxt;
        end
    end

    // audio pins: pass-through in run, grounded while armed
    always_comb begin
        if (s_r.armed) begin
            audio_out_pos_out = 1'b0;
            audio_out_neg_out = 1'b0;
            audio_oe_out      = 1'b1;
        end else begin
            audio_out_pos_out = audio_pos_in;
            audio_out_neg_out = audio_neg_in;
            audio_oe_out      = (s_r.mode != HWK_HALT);
        end
    end

    assign prdata_out      = s_r.rdata;
    assign pready_out      = 1'b1;
    assign pslverr_out     = psel_in && penable_in && !mapped;
    assign halted_out      = (s_r.mode == HWK_HALT);
    assign wake_out        = s_r.wake;
    assign wake_vector_out = WAKE_VECTOR;
    assign sys_reset_out   = s_r.sysrst;
    assign irq_out         = |(s_r.stat & s_r.mask);
endmodule
